// File: rtl/tsp_consts.svh
`ifndef TSP_CONSTS_SVH
`define TSP_CONSTS_SVH

`define TSP_NUM_PORTS     32
`define TSP_CLK_PERIOD_NS 20
`define TSP_CLK_HIGH_NS   60
`define TSP_CLK_HIGH_CYC  ((`TSP_CLK_HIGH_NS + `TSP_CLK_PERIOD_NS - 1) / `TSP_CLK_PERIOD_NS)
`define TSP_CNT_W         3
`define TSP_PORT1         0

`endif

// File: rtl/tsp_pkg.sv
`include "tsp_consts.svh"
package tsp_pkg;
  typedef logic [`TSP_NUM_PORTS-1:0] tsp_port_vec_t;
  typedef logic [`TSP_CNT_W-1:0]     tsp_cnt_t;
endpackage

// File: rtl/tsp_top.sv
`timescale 1ns/1ns
`include "tsp_consts.svh"
module tsp_top (
  // Clock and reset
  input  wire  logic                   CLK,
  input  wire  logic                   RESET_N,
  // Mode and edge selection
  input  wire  logic                   UNCHANNELIZED,
  input  wire  tsp_pkg::tsp_port_vec_t RX_EDGE_FALL,
  input  wire  tsp_pkg::tsp_port_vec_t TX_EDGE_FALL,
  // Demultiplexed receive bits
  input  wire  tsp_pkg::tsp_port_vec_t RX_STROBE,
  input  wire  tsp_pkg::tsp_port_vec_t RX_BIT,
  // Line side payload ticks
  input  wire  logic                   LINE_RX_TICK,
  input  wire  logic                   LINE_RX_OVH,
  input  wire  logic                   LINE_RX_BIT,
  input  wire  logic                   LINE_TX_TICK,
  input  wire  logic                   LINE_TX_OVH,
  // Tributary receive pins
  output logic                         TRIB_RX_CLOCK_UNUSED_NEVER,
  output tsp_pkg::tsp_port_vec_t       TRIB_RX_CLOCK,
  output tsp_pkg::tsp_port_vec_t       TRIB_RX_DATA,
  // Tributary transmit pins
  input  wire  tsp_pkg::tsp_port_vec_t TRIB_TX_CLOCK_I,
  output logic                         TRIB_TX_CLOCK_O,
  output logic                         TRIB_TX_CLOCK_OE,
  input  wire  tsp_pkg::tsp_port_vec_t TRIB_TX_DATA,
  // Sampled transmit bits toward the mux
  output tsp_pkg::tsp_port_vec_t       TX_STROBE,
  output tsp_pkg::tsp_port_vec_t       TX_BIT
);
  import tsp_pkg::*;

  localparam tsp_cnt_t HIGH_CYC = tsp_cnt_t'(`TSP_CLK_HIGH_CYC);
  localparam tsp_cnt_t FULL_CYC = tsp_cnt_t'(2 * `TSP_CLK_HIGH_CYC);

  // Mode and edge selection state
  tsp_port_vec_t rx_fall_q;
  tsp_port_vec_t rx_fall_d;
  tsp_port_vec_t tx_fall_q;
  tsp_port_vec_t tx_fall_d;
  logic          unchan_q;
  logic          unchan_d;

  // Receive state
  tsp_port_vec_t rx_clk_q;
  tsp_port_vec_t rx_clk_d;
  tsp_port_vec_t rx_data_q;
  tsp_port_vec_t rx_data_d;
  tsp_port_vec_t rx_stage_q;
  tsp_port_vec_t rx_stage_d;
  tsp_port_vec_t rx_late_q;
  tsp_port_vec_t rx_late_d;
  tsp_cnt_t      rx_cnt_q [`TSP_NUM_PORTS];
  tsp_cnt_t      rx_cnt_d [`TSP_NUM_PORTS];

  // Pin synchroniser state
  tsp_port_vec_t txc_s1_q;
  tsp_port_vec_t txc_s1_d;
  tsp_port_vec_t txc_s2_q;
  tsp_port_vec_t txc_s2_d;
  tsp_port_vec_t txc_s3_q;
  tsp_port_vec_t txc_s3_d;
  tsp_port_vec_t txd_s1_q;
  tsp_port_vec_t txd_s1_d;
  tsp_port_vec_t txd_s2_q;
  tsp_port_vec_t txd_s2_d;

  // Transmit state
  logic          tx1_clk_q;
  logic          tx1_clk_d;
  logic          tx1_oe_q;
  logic          tx1_oe_d;
  tsp_cnt_t      tx1_cnt_q;
  tsp_cnt_t      tx1_cnt_d;
  tsp_port_vec_t tx_stb_q;
  tsp_port_vec_t tx_stb_d;
  tsp_port_vec_t tx_bit_q;
  tsp_port_vec_t tx_bit_d;
  logic          tx1_rise;

  // Spare output state
  logic          spare_q;
  logic          spare_d;

  // Pulse counter step: count down while nonzero, load on start at zero, else hold zero
  function automatic tsp_cnt_t cnt_step(input tsp_cnt_t cnt, input logic start);
    if (cnt != '0) begin
      cnt_step = cnt - tsp_cnt_t'(1);
    end else if (start) begin
      cnt_step = FULL_CYC;
    end else begin
      cnt_step = '0;
    end
  endfunction

  // New pulse only while the counter is idle
  function automatic logic cnt_start(input tsp_cnt_t cnt, input logic start);
    cnt_start = (cnt == '0) && start;
  endfunction

  // High time over, clock drops
  function automatic logic cnt_drop(input tsp_cnt_t cnt);
    cnt_drop = (cnt == HIGH_CYC + tsp_cnt_t'(1));
  endfunction

  always_comb begin
    rx_fall_d = RX_EDGE_FALL;
    tx_fall_d = TX_EDGE_FALL;
    unchan_d  = UNCHANNELIZED;
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rx_fall_q <= '0;
      tx_fall_q <= '0;
      unchan_q  <= 1'h0;
    end else begin
      rx_fall_q <= rx_fall_d;
      tx_fall_q <= tx_fall_d;
      unchan_q  <= unchan_d;
    end
  end

  // Receive side
  always_comb begin
    logic strobe;
    logic bit_in;
    logic fall;
    strobe     = 1'h0;
    bit_in     = 1'h0;
    fall       = 1'h0;
    rx_clk_d   = rx_clk_q;
    rx_data_d  = rx_data_q;
    rx_stage_d = rx_stage_q;
    rx_late_d  = rx_late_q;
    for (int i = 0; i < `TSP_NUM_PORTS; i++) begin
      if (unchan_q && i == `TSP_PORT1) begin
        strobe = LINE_RX_TICK && !LINE_RX_OVH;
        bit_in = LINE_RX_BIT;
        fall   = 1'h1;
      end else begin
        strobe = RX_STROBE[i];
        bit_in = RX_BIT[i];
        fall   = rx_fall_q[i];
      end
      rx_cnt_d[i] = cnt_step(rx_cnt_q[i], strobe);
      if (cnt_start(rx_cnt_q[i], strobe)) begin
        rx_clk_d[i] = 1'h1;
        if (fall) begin
          rx_stage_d[i] = bit_in;
          rx_late_d[i]  = 1'h1;
        end else begin
          rx_data_d[i]  = bit_in;
          rx_late_d[i]  = 1'h0;
        end
      end else if (cnt_drop(rx_cnt_q[i])) begin
        rx_clk_d[i] = 1'h0;
        if (rx_late_q[i]) begin
          rx_data_d[i] = rx_stage_q[i];
          rx_late_d[i] = 1'h0;
        end
      end
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      rx_clk_q   <= '0;
      rx_data_q  <= '0;
      rx_stage_q <= '0;
      rx_late_q  <= '0;
      for (int i = 0; i < `TSP_NUM_PORTS; i++) begin
        rx_cnt_q[i] <= '0;
      end
    end else begin
      rx_clk_q   <= rx_clk_d;
      rx_data_q  <= rx_data_d;
      rx_stage_q <= rx_stage_d;
      rx_late_q  <= rx_late_d;
      for (int i = 0; i < `TSP_NUM_PORTS; i++) begin
        rx_cnt_q[i] <= rx_cnt_d[i];
      end
    end
  end

  // Pin synchronisers, two flops before any logic
  always_comb begin
    txc_s1_d = TRIB_TX_CLOCK_I;
    txc_s2_d = txc_s1_q;
    txc_s3_d = txc_s2_q;
    txd_s1_d = TRIB_TX_DATA;
    txd_s2_d = txd_s1_q;
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      txc_s1_q <= '0;
      txc_s2_q <= '0;
      txc_s3_q <= '0;
      txd_s1_q <= '0;
      txd_s2_q <= '0;
    end else begin
      txc_s1_q <= txc_s1_d;
      txc_s2_q <= txc_s2_d;
      txc_s3_q <= txc_s3_d;
      txd_s1_q <= txd_s1_d;
      txd_s2_q <= txd_s2_d;
    end
  end

  // Transmit side
  always_comb begin
    logic rise_edge;
    logic fall_edge;
    logic slot;
    rise_edge = 1'h0;
    fall_edge = 1'h0;
    slot      = LINE_TX_TICK && !LINE_TX_OVH;
    tx1_rise  = 1'h0;
    tx1_clk_d = 1'h0;
    tx1_oe_d  = 1'h0;
    tx1_cnt_d = '0;
    tx_stb_d  = '0;
    tx_bit_d  = tx_bit_q;
    if (unchan_q) begin
      tx1_oe_d  = 1'h1;
      tx1_clk_d = tx1_clk_q;
      tx1_cnt_d = cnt_step(tx1_cnt_q, slot);
      if (cnt_start(tx1_cnt_q, slot)) begin
        tx1_clk_d = 1'h1;
        tx1_rise  = 1'h1;
      end else if (cnt_drop(tx1_cnt_q)) begin
        tx1_clk_d = 1'h0;
      end
    end
    for (int i = 0; i < `TSP_NUM_PORTS; i++) begin
      rise_edge = txc_s2_q[i] && !txc_s3_q[i];
      fall_edge = !txc_s2_q[i] && txc_s3_q[i];
      if (unchan_q && i == `TSP_PORT1) begin
        tx_stb_d[i] = tx1_rise;
      end else begin
        tx_stb_d[i] = tx_fall_q[i] ? fall_edge : rise_edge;
      end
      if (tx_stb_d[i]) begin
        tx_bit_d[i] = txd_s2_q[i];
      end
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      tx1_clk_q <= 1'h0;
      tx1_oe_q  <= 1'h0;
      tx1_cnt_q <= '0;
      tx_stb_q  <= '0;
      tx_bit_q  <= '0;
    end else begin
      tx1_clk_q <= tx1_clk_d;
      tx1_oe_q  <= tx1_oe_d;
      tx1_cnt_q <= tx1_cnt_d;
      tx_stb_q  <= tx_stb_d;
      tx_bit_q  <= tx_bit_d;
    end
  end

  // Spare output held low
  always_comb begin
    spare_d = 1'h0;
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      spare_q <= 1'h0;
    end else begin
      spare_q <= spare_d;
    end
  end

  // Outputs straight from flops
  always_comb begin
    TRIB_RX_CLOCK_UNUSED_NEVER = spare_q;
  end

  assign TRIB_RX_CLOCK    = rx_clk_q;
  assign TRIB_RX_DATA     = rx_data_q;
  assign TRIB_TX_CLOCK_O  = tx1_clk_q;
  assign TRIB_TX_CLOCK_OE = tx1_oe_q;
  assign TX_STROBE        = tx_stb_q;
  assign TX_BIT           = tx_bit_q;

endmodule // tsp_top

// File: dv/tsp_chk.sv
`timescale 1ns/1ns
module tsp_chk (
  // Clock and reset
  input wire logic                   CLK,
  input wire logic                   RESET_N,
  // Watched pins
  input wire logic                   UNCHANNELIZED,
  input wire tsp_pkg::tsp_port_vec_t RX_EDGE_FALL,
  input wire tsp_pkg::tsp_port_vec_t RX_STROBE,
  input wire tsp_pkg::tsp_port_vec_t RX_BIT,
  input wire logic                   LINE_RX_TICK,
  input wire logic                   LINE_RX_OVH,
  input wire tsp_pkg::tsp_port_vec_t TRIB_RX_CLOCK,
  input wire tsp_pkg::tsp_port_vec_t TRIB_RX_DATA,
  input wire logic                   TRIB_TX_CLOCK_OE
);
  import tsp_pkg::*;
  logic c, d, c0, d0, u, t;
  assign c = TRIB_RX_CLOCK[4];
  assign d = TRIB_RX_DATA[4];
  assign c0 = TRIB_RX_CLOCK[0];
  assign d0 = TRIB_RX_DATA[0];
  assign u = UNCHANNELIZED;
  assign t = LINE_RX_TICK & ~LINE_RX_OVH;
  default clocking @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  clk_cause_a: assert property ($rose(c) |-> $past(RX_STROBE[4])) else $error("clock without strobe");
  clk_high_a: assert property ($rose(c) |-> c [*3] ##1 !c) else $error("clock high time");
  gap_low_a: assert property ($fell(c) |-> !c [*3]) else $error("clock low time");
  rise_data_a: assert property ($rose(c) && !RX_EDGE_FALL[4] |-> d == $past(RX_BIT[4]))
    else $error("data on rising edge");
  fall_data_a: assert property ($rose(c) && RX_EDGE_FALL[4] |-> ##3 $fell(c) && d == $past(RX_BIT[4], 4))
    else $error("data on falling edge");
  payload_clk_a: assert property ($rose(c0) && u && $past(u, 2) |-> $past(t))
    else $error("payload clock cause");
  payload_dat_a: assert property ($changed(d0) && u && $past(u, 8) |-> $fell(c0))
    else $error("payload data edge");
  tx_drive_a: assert property (u [*3] |-> TRIB_TX_CLOCK_OE) else $error("port 1 clock not driven");
endmodule // tsp_chk
bind tsp_top tsp_chk chk_u (.CLK, .RESET_N, .UNCHANNELIZED, .RX_EDGE_FALL, .RX_STROBE, .RX_BIT, .LINE_RX_TICK,
  .LINE_RX_OVH, .TRIB_RX_CLOCK, .TRIB_RX_DATA, .TRIB_TX_CLOCK_OE);

// File: dv/tsp_far.sv
`timescale 1ns/1ns
module tsp_far (
  // Clock and reset
  input  wire logic                   clk,
  input  wire logic                   rst_n,
  // Edge choice and pins
  input  wire tsp_pkg::tsp_port_vec_t fall,
  output tsp_pkg::tsp_port_vec_t      tclk_q,
  output tsp_pkg::tsp_port_vec_t      tdat_q
);
  import tsp_pkg::*;
  logic [3:0] cnt_q;
  always_ff @(negedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q <= '0;
      tclk_q <= '0;
      tdat_q <= '0;
    end else begin
      cnt_q <= cnt_q + 4'h1;
      if (cnt_q == 4'hF) begin
        tclk_q <= ~tclk_q;
        tdat_q <= (tdat_q & ~(tclk_q ^ fall)) | ($urandom & (tclk_q ^ fall));
      end
    end
  end
endmodule // tsp_far

// File: dv/tb_top.sv
`timescale 1ns/1ns
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; $display("ERROR %0t bad value", $time); end end
module tb_top;
  import tsp_pkg::*;
  logic          CLK, RESET_N, UNCHANNELIZED, LINE_RX_TICK, LINE_RX_OVH, LINE_RX_BIT;
  logic          LINE_TX_TICK, LINE_TX_OVH, TRIB_TX_CLOCK_O, TRIB_TX_CLOCK_OE;
  logic          TRIB_RX_CLOCK_UNUSED_NEVER, txe;
  tsp_port_vec_t RX_EDGE_FALL, TX_EDGE_FALL, RX_STROBE, RX_BIT, TRIB_RX_CLOCK, TRIB_RX_DATA;
  tsp_port_vec_t TRIB_TX_CLOCK_I, TRIB_TX_DATA, TX_STROBE, TX_BIT, far_clk, expd;
  int            miscompares = 0, checks = 0, cyc = 0;
  assign TRIB_TX_CLOCK_I = {far_clk[31:1], TRIB_TX_CLOCK_OE ? TRIB_TX_CLOCK_O : far_clk[0]};
  tsp_top dut_u (.CLK, .RESET_N, .UNCHANNELIZED, .RX_EDGE_FALL, .TX_EDGE_FALL, .RX_STROBE, .RX_BIT,
    .LINE_RX_TICK, .LINE_RX_OVH, .LINE_RX_BIT, .LINE_TX_TICK, .LINE_TX_OVH, .TRIB_RX_CLOCK_UNUSED_NEVER,
    .TRIB_RX_CLOCK, .TRIB_RX_DATA, .TRIB_TX_CLOCK_I, .TRIB_TX_CLOCK_O, .TRIB_TX_CLOCK_OE, .TRIB_TX_DATA,
    .TX_STROBE, .TX_BIT);
  tsp_far far_u (.clk(CLK), .rst_n(RESET_N), .fall(TX_EDGE_FALL), .tclk_q(far_clk), .tdat_q(TRIB_TX_DATA));
  function automatic tsp_port_vec_t nxt(tsp_port_vec_t o, tsp_port_vec_t s, tsp_port_vec_t b, logic u);
    tsp_port_vec_t m;
    m = u ? {s[31:1], LINE_RX_TICK & ~LINE_RX_OVH} : s;
    nxt = (o & ~m) | ({b[31:1], u ? LINE_RX_BIT : b[0]} & m);
  endfunction
  task automatic tally_and_finish;
    if (miscompares == 0 && checks > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  initial begin
    CLK = 0;
    forever #10 CLK = ~CLK;
  end
  always @(posedge CLK) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      miscompares++;
      tally_and_finish;
    end
  end
  always @(negedge CLK) if (RESET_N) `CHK(TX_BIT & TX_STROBE & ~{31'h0, UNCHANNELIZED}, TRIB_TX_DATA & TX_STROBE & ~{31'h0, UNCHANNELIZED})
  initial begin
    void'($urandom(80));
    {UNCHANNELIZED, LINE_RX_TICK, LINE_RX_OVH, LINE_RX_BIT, LINE_TX_TICK, LINE_TX_OVH} = '0;
    {RX_STROBE, RX_BIT, expd} = '0;
    txe = 1'h0;
    RX_EDGE_FALL = $urandom;
    TX_EDGE_FALL = $urandom;
    RESET_N = 0;
    repeat (16) @(negedge CLK);
    RESET_N = 1;
    for (int n = 0; n < 6000; n++) begin
      @(negedge CLK);
      {RX_STROBE, LINE_RX_TICK, LINE_TX_TICK} = '0;
      if (n % 8 == 7) begin
        `CHK(TRIB_RX_DATA, expd)
        `CHK(TRIB_RX_CLOCK, 32'h0000_0000)
        `CHK(TRIB_RX_CLOCK_UNUSED_NEVER, 1'h0)
        `CHK(TRIB_TX_CLOCK_O, 1'h0)
        `CHK(TRIB_TX_CLOCK_OE, UNCHANNELIZED)
        if (n == 1495) RX_EDGE_FALL = ~RX_EDGE_FALL;
      end
      if (n == 3003) UNCHANNELIZED = 1;
      if (n % 8 == 1 && n > 3010) begin
        `CHK(TX_STROBE[0], txe)
        `CHK(TRIB_TX_CLOCK_O, txe)
      end
      if (n % 8 == 0) begin
        RX_STROBE = (n == 8) ? '1 : $urandom;
        RX_BIT = $urandom;
        {LINE_RX_TICK, LINE_RX_OVH, LINE_RX_BIT, LINE_TX_TICK, LINE_TX_OVH} = 5'($urandom);
        expd = nxt(expd, RX_STROBE, RX_BIT, UNCHANNELIZED);
        txe = LINE_TX_TICK & ~LINE_TX_OVH;
      end
    end
    tally_and_finish;
  end
endmodule // tb_top
